// ==== shbp_map.svh ====
// Register offsets, reset values and field positions of the strobe host bus port
`ifndef SHBP_MAP_SVH
`define SHBP_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SHBP_ADDR_MODE 7'h00
`define SHBP_ADDR_STATUS 7'h01
`define SHBP_ADDR_BAUD 7'h02
`define SHBP_ADDR_CTRL 7'h03
`define SHBP_ADDR_IMR_LO 7'h04
`define SHBP_ADDR_IMR_HI 7'h05
`define SHBP_ADDR_ISR_LO 7'h06
`define SHBP_ADDR_ISR_HI 7'h07
`define SHBP_ADDR_OPR 7'h08
`define SHBP_ADDR_OUT_PORT_CFG_REG 7'h09
`define SHBP_ADDR_VECTOR 7'h0A

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SHBP_MODE1_RST 8'h13
`define SHBP_MODE2_RST 8'h07
`define SHBP_BAUD_9600 8'h0B
`define SHBP_VECTOR_RST 8'h0F
`define SHBP_PIN_RST 21'h1FFFFF

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SHBP_CTRL_TIMER 0
`define SHBP_CTRL_RX_EN 1
`define SHBP_CTRL_TX_EN 2
`define SHBP_CTRL_LOOP 3
`define SHBP_CTRL_PTR_RST 4

`endif

// ==== shbp_pkg.sv ====
// Types shared by the strobe host bus port files
package shbp_pkg;

  typedef struct packed {
    logic bus_style_select;
    logic rxd;
    logic chip_select_n;
    logic write_strobe_n;
    logic read_strobe_n;
    logic irq_ack_n;
    logic [6:0] addr;
    logic [7:0] data;
  } shbp_pins_t;

  typedef enum logic [0:0] {
    SHBP_PTR_FIRST = 1'b0,
    SHBP_PTR_SECOND = 1'b1
  } shbp_ptr_t;

  typedef struct packed {
    logic wr_prev;
    logic wr_armed;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    shbp_ptr_t ptr;
    logic [7:0] first_mode_reg;
    logic [7:0] second_mode_reg;
    logic [7:0] baud_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] channel_status_reg;
    logic [10:0] int_mask_reg;
    logic [10:0] int_status_reg;
    logic [7:0] out_port_reg;
    logic [7:0] out_port_cfg_reg;
    logic [7:0] vector_reg;
    logic [7:0] data_out;
    logic data_oe;
    logic irq_oe;
    logic txd;
    logic rx_level;
  } shbp_state_t;

endpackage : shbp_pkg

// ==== shbp_sync.sv ====
// Three-stage pin synchroniser, output changes once stages two and three agree
`timescale 1ns/1ns
module shbp_sync #(
  parameter int W = 21,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk,          // System clock
  input wire logic rst,          // Asynchronous reset, active high
  input wire logic [W-1:0] d,    // Raw pin levels
  output logic [W-1:0] q         // Filtered, synchronised levels
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } shbp_sync_state_t;

  shbp_sync_state_t r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (r_reg.s2[i] == r_reg.s3[i]) begin
        r_next.q[i] = r_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= {4{RST_VAL}};
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.q;

endmodule : shbp_sync

// ==== shbp_mem.sv ====
// General register storage for addresses without dedicated logic
`timescale 1ns/1ns
module shbp_mem (
  input wire logic clk,          // System clock
  input wire logic we,           // Write enable
  input wire logic [6:0] waddr,  // Write address
  input wire logic [7:0] wdata,  // Write data
  input wire logic [6:0] raddr,  // Read address
  output logic [7:0] rdata       // Registered read data
);

  logic [7:0] mem_reg [0:127];
  logic [7:0] rdata_reg;

  always_ff @(posedge clk) begin
    if (we) begin
      mem_reg[waddr] <= wdata;
    end
    rdata_reg <= mem_reg[raddr];
  end

  assign rdata = rdata_reg;

endmodule : shbp_mem

// ==== shbp_port.sv ====
// Strobe-style host bus port: pin decode, registers, interrupt request, vector cycle
//
// Summary of operation
// - Strobe bus style active only while bus style select is high or floating.
// - Eight-bit three-state data bus carries commands, data and status, bit 0 LSB.
// - Data bus driven only while chip select or interrupt acknowledge low, else all lines released.
// - Host holds select and write strobe low; register loads at strobe rising edge.
// - Select and read strobe low drive the addressed register onto the data bus.
// - Seven-bit address chooses the register or port being accessed.
// - Reset clears status, interrupt mask, interrupt status, output port and its config.
// - Reset releases all eight port pins as inputs and halts the timer.
// - Reset makes the channel inactive with transmit output at mark.
// - Reset points mode pointer at first mode register, 9600 baud 8N1.
// - Interrupt request pulled low while any of eleven unmasked latched interrupt status bits is set.
// - Interrupt acknowledge low drives the interrupt vector onto the data bus.
// - Receive data sampled with high as mark and low as space, LSB first.
// - Transmit output held at mark while disabled, idle or in local loopback.
`timescale 1ns/1ns
`include "shbp_map.svh"
module shbp_port (
  input wire logic clk,                 // System clock, 100 MHz
  input wire logic rst,                 // Asynchronous reset, active high
  input wire logic bus_style_select,    // High or floating selects strobe style
  input wire logic chip_select_n,       // Chip select, active low
  input wire logic write_strobe_n,      // Write strobe, active low
  input wire logic read_strobe_n,       // Read strobe, active low
  input wire logic irq_ack_n,           // Interrupt acknowledge, active low
  input wire logic [6:0] addr,          // Register address
  input wire logic [7:0] data_in,       // Data bus level seen on the pins
  output logic [7:0] data_out,          // Data bus drive value
  output logic data_oe,                 // Data bus output enable
  output logic irq_out_n,               // Interrupt request drive value, always low
  output logic irq_oe,                  // Interrupt request pull-down enable
  input wire logic [10:0] int_cond,     // Interrupt condition levels
  input wire logic [7:0] chan_status,   // Channel status from the serial datapath
  input wire logic rxd,                 // Serial receive pin
  output logic rx_level,                // Synchronised receive level, high is mark
  input wire logic tx_bit,              // Serial transmit bit from datapath
  input wire logic tx_busy,             // Transmitter shifting a character
  output logic txd,                     // Serial transmit pin
  output logic [7:0] io_out,            // Port pin drive values
  output logic [7:0] io_oe,             // Port pin output enables
  output logic timer_run,               // Counter/timer run enable
  output logic rx_enable,               // Receiver enable
  output logic tx_enable,               // Transmitter enable
  output logic loopback,                // Local loopback mode
  output logic [7:0] mode1,             // First mode register value
  output logic [7:0] mode2,             // Second mode register value
  output logic [7:0] baud_sel           // Baud rate select code
);

  shbp_pkg::shbp_pins_t pins_raw;
  shbp_pkg::shbp_pins_t s;
  shbp_pkg::shbp_state_t r_reg, r_next;
  logic [7:0] mem_rdata;
  logic wr_commit;
  logic mem_we;
  logic [7:0] rd_val;

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_named(input logic [6:0] a);
    case (a)
      `SHBP_ADDR_MODE, `SHBP_ADDR_STATUS, `SHBP_ADDR_BAUD, `SHBP_ADDR_CTRL,
      `SHBP_ADDR_IMR_LO, `SHBP_ADDR_IMR_HI, `SHBP_ADDR_ISR_LO, `SHBP_ADDR_ISR_HI,
      `SHBP_ADDR_OPR, `SHBP_ADDR_OUT_PORT_CFG_REG, `SHBP_ADDR_VECTOR: is_named = 1'b1;
      default: is_named = 1'b0;
    endcase
  endfunction : is_named

  function automatic logic [7:0] read_mux(input shbp_pkg::shbp_state_t st,
                                          input logic [6:0] a,
                                          input logic [7:0] mem);
    case (a)
      `SHBP_ADDR_MODE: begin
        read_mux = (st.ptr == shbp_pkg::SHBP_PTR_FIRST) ? st.first_mode_reg
                                                        : st.second_mode_reg;
      end
      `SHBP_ADDR_STATUS: read_mux = st.channel_status_reg;
      `SHBP_ADDR_BAUD: read_mux = st.baud_reg;
      `SHBP_ADDR_CTRL: read_mux = st.ctrl_reg;
      `SHBP_ADDR_IMR_LO: read_mux = st.int_mask_reg[7:0];
      `SHBP_ADDR_IMR_HI: read_mux = {5'h00, st.int_mask_reg[10:8]};
      `SHBP_ADDR_ISR_LO: read_mux = st.int_status_reg[7:0];
      `SHBP_ADDR_ISR_HI: read_mux = {5'h00, st.int_status_reg[10:8]};
      `SHBP_ADDR_OPR: read_mux = st.out_port_reg;
      `SHBP_ADDR_OUT_PORT_CFG_REG: read_mux = st.out_port_cfg_reg;
      `SHBP_ADDR_VECTOR: read_mux = st.vector_reg;
      default: read_mux = mem;
    endcase
  endfunction : read_mux

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  assign pins_raw = '{bus_style_select: bus_style_select, rxd: rxd,
                      chip_select_n: chip_select_n, write_strobe_n: write_strobe_n,
                      read_strobe_n: read_strobe_n, irq_ack_n: irq_ack_n,
                      addr: addr, data: data_in};

  shbp_sync #(.W(21), .RST_VAL(`SHBP_PIN_RST)) u_sync (
    .clk(clk),
    .rst(rst),
    .d(pins_raw),
    .q(s)
  );

  shbp_mem u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(r_reg.wr_addr),
    .wdata(r_reg.wr_data),
    .raddr(s.addr),
    .rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Write strobe: capture while low, commit on the rising edge
  // ----------------------------------------------------------------
  assign wr_commit = r_reg.wr_armed && !r_reg.wr_prev && s.write_strobe_n;
  assign mem_we = wr_commit && !is_named(r_reg.wr_addr);
  assign rd_val = read_mux(r_reg, s.addr, mem_rdata);

  always_comb begin
    r_next = r_reg;
    r_next.wr_prev = s.write_strobe_n;
    if (!s.bus_style_select || s.chip_select_n) begin
      r_next.wr_armed = 1'b0;
    end else if (!s.write_strobe_n) begin
      r_next.wr_armed = 1'b1;
      r_next.wr_addr = s.addr;
      r_next.wr_data = s.data;
    end else if (wr_commit) begin
      r_next.wr_armed = 1'b0;
    end

    // Status follows the datapath only while the channel runs
    r_next.channel_status_reg = (r_reg.ctrl_reg[`SHBP_CTRL_RX_EN] ||
                                 r_reg.ctrl_reg[`SHBP_CTRL_TX_EN]) ? chan_status : 8'h00;

    // Interrupt status: writing ones clears, a new event wins over the clear
    if (wr_commit && r_reg.wr_addr == `SHBP_ADDR_ISR_LO) begin
      r_next.int_status_reg[7:0] = r_reg.int_status_reg[7:0] & ~r_reg.wr_data;
    end
    if (wr_commit && r_reg.wr_addr == `SHBP_ADDR_ISR_HI) begin
      r_next.int_status_reg[10:8] = r_reg.int_status_reg[10:8] & ~r_reg.wr_data[2:0];
    end
    r_next.int_status_reg = r_next.int_status_reg | int_cond;

    if (wr_commit) begin
      case (r_reg.wr_addr)
        `SHBP_ADDR_MODE: begin
          if (r_reg.ptr == shbp_pkg::SHBP_PTR_FIRST) begin
            r_next.first_mode_reg = r_reg.wr_data;
            r_next.ptr = shbp_pkg::SHBP_PTR_SECOND;
          end else begin
            r_next.second_mode_reg = r_reg.wr_data;
          end
        end
        `SHBP_ADDR_BAUD: r_next.baud_reg = r_reg.wr_data;
        `SHBP_ADDR_CTRL: begin
          r_next.ctrl_reg = {3'h0, 1'b0, r_reg.wr_data[3:0]};
          if (r_reg.wr_data[`SHBP_CTRL_PTR_RST]) begin
            r_next.ptr = shbp_pkg::SHBP_PTR_FIRST;
          end
        end
        `SHBP_ADDR_IMR_LO: r_next.int_mask_reg[7:0] = r_reg.wr_data;
        `SHBP_ADDR_IMR_HI: r_next.int_mask_reg[10:8] = r_reg.wr_data[2:0];
        `SHBP_ADDR_OPR: r_next.out_port_reg = r_reg.wr_data;
        `SHBP_ADDR_OUT_PORT_CFG_REG: r_next.out_port_cfg_reg = r_reg.wr_data;
        `SHBP_ADDR_VECTOR: r_next.vector_reg = r_reg.wr_data;
        default: r_next.ctrl_reg = r_next.ctrl_reg;
      endcase
    end

    // Data bus drive: acknowledge cycle first, then register read
    r_next.data_oe = 1'b0;
    if (s.bus_style_select && !s.irq_ack_n) begin
      r_next.data_oe = 1'b1;
      r_next.data_out = r_reg.vector_reg;
    end else if (s.bus_style_select && !s.chip_select_n && !s.read_strobe_n) begin
      r_next.data_oe = 1'b1;
      r_next.data_out = rd_val;
    end

    r_next.irq_oe = |(r_reg.int_status_reg & r_reg.int_mask_reg);
    r_next.rx_level = s.rxd;
    r_next.txd = (r_reg.ctrl_reg[`SHBP_CTRL_TX_EN] && tx_busy &&
                  !r_reg.ctrl_reg[`SHBP_CTRL_LOOP]) ? tx_bit : 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.wr_prev <= 1'b1;
      r_reg.ptr <= shbp_pkg::SHBP_PTR_FIRST;
      r_reg.first_mode_reg <= `SHBP_MODE1_RST;
      r_reg.second_mode_reg <= `SHBP_MODE2_RST;
      r_reg.baud_reg <= `SHBP_BAUD_9600;
      r_reg.vector_reg <= `SHBP_VECTOR_RST;
      r_reg.txd <= 1'b1;
      r_reg.rx_level <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign data_out = r_reg.data_out;
  assign data_oe = r_reg.data_oe;
  assign irq_out_n = 1'b0;
  assign irq_oe = r_reg.irq_oe;
  assign rx_level = r_reg.rx_level;
  assign txd = r_reg.txd;
  assign io_out = r_reg.out_port_reg;
  assign io_oe = r_reg.out_port_cfg_reg;
  assign timer_run = r_reg.ctrl_reg[`SHBP_CTRL_TIMER];
  assign rx_enable = r_reg.ctrl_reg[`SHBP_CTRL_RX_EN];
  assign tx_enable = r_reg.ctrl_reg[`SHBP_CTRL_TX_EN];
  assign loopback = r_reg.ctrl_reg[`SHBP_CTRL_LOOP];
  assign mode1 = r_reg.first_mode_reg;
  assign mode2 = r_reg.second_mode_reg;
  assign baud_sel = r_reg.baud_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_write_imr;
    wr_commit && r_reg.wr_addr == `SHBP_ADDR_IMR_LO;
  endsequence
  sequence s_mode_first;
    wr_commit && r_reg.wr_addr == `SHBP_ADDR_MODE && r_reg.ptr == shbp_pkg::SHBP_PTR_FIRST;
  endsequence

  property p_oe_select;
    data_oe |-> $past(!s.chip_select_n || !s.irq_ack_n);
  endproperty
  a_oe_select: assert property (p_oe_select) else $error("bus driven without select");
  property p_write_load;
    s_write_imr |=> r_reg.int_mask_reg[7:0] == $past(r_reg.wr_data);
  endproperty
  a_write_load: assert property (p_write_load) else $error("mask write not loaded");
  property p_read_opr;
    (s.bus_style_select && s.irq_ack_n && !s.chip_select_n && !s.read_strobe_n &&
     s.addr == `SHBP_ADDR_OPR) |=> (data_oe && data_out == $past(r_reg.out_port_reg));
  endproperty
  a_read_opr: assert property (p_read_opr) else $error("read data wrong");
  property p_irq;
    (|(r_reg.int_status_reg & r_reg.int_mask_reg)) |=> irq_oe;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not requested");
  property p_ack;
    (s.bus_style_select && !s.irq_ack_n) |=> (data_oe && data_out == $past(r_reg.vector_reg));
  endproperty
  a_ack: assert property (p_ack) else $error("vector not driven");
  property p_mark;
    (!tx_enable || loopback || !tx_busy) |=> txd;
  endproperty
  a_mark: assert property (p_mark) else $error("transmit not at mark");
  property p_no_select;
    (s.chip_select_n [*2]) |-> !wr_commit;
  endproperty
  a_no_select: assert property (p_no_select) else $error("write while deselected");
  property p_style;
    (!s.bus_style_select [*2]) |-> !wr_commit;
  endproperty
  a_style: assert property (p_style) else $error("write in other bus style");
  property p_ptr;
    s_mode_first |=> r_reg.ptr == shbp_pkg::SHBP_PTR_SECOND;
  endproperty
  a_ptr: assert property (p_ptr) else $error("mode pointer not advanced");
  sequence s_ptr_rst;
    wr_commit && r_reg.wr_addr == `SHBP_ADDR_CTRL && r_reg.wr_data[`SHBP_CTRL_PTR_RST];
  endsequence
  property p_ptr_rst;
    s_ptr_rst |=> r_reg.ptr == shbp_pkg::SHBP_PTR_FIRST;
  endproperty
  a_ptr_rst: assert property (p_ptr_rst) else $error("mode pointer not rewound");
  property p_release;
    (!s.bus_style_select || (s.chip_select_n && s.irq_ack_n)) |=> !data_oe;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");
  property p_isr_sticky;
    (|int_cond) |=> ((r_reg.int_status_reg & $past(int_cond)) == $past(int_cond));
  endproperty
  a_isr_sticky: assert property (p_isr_sticky) else $error("event not latched");
  property p_irq_idle;
    !(|(r_reg.int_status_reg & r_reg.int_mask_reg)) |=> !irq_oe;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("request without cause");
  property p_rx_level;
    1'b1 |=> rx_level == $past(s.rxd);
  endproperty
  a_rx_level: assert property (p_rx_level) else $error("receive level wrong");
  property p_reset;
    @(posedge clk) disable iff (1'b0) rst [*2] |-> (io_oe == 8'h00 && txd && !timer_run &&
                                                    r_reg.int_mask_reg == 11'h000);
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

endmodule : shbp_port

// ==== shbp_host_model.sv ====
// Host processor model that drives the strobe pins of the port
`timescale 1ns/1ns
module shbp_host_model (
  input wire logic clk,              // System clock
  input wire logic [7:0] data_out,   // Port data drive value
  input wire logic data_oe,          // Port data drive enable
  output logic chip_select_n,        // Chip select, active low
  output logic write_strobe_n,       // Write strobe, active low
  output logic read_strobe_n,        // Read strobe, active low
  output logic irq_ack_n,            // Interrupt acknowledge, active low
  output logic [6:0] addr,           // Register address
  output logic [7:0] data_in         // Resolved data bus level
);
  logic drv;
  logic [7:0] drv_val;
  logic [7:0] last_val;

  initial begin
    chip_select_n = 1'b1;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    irq_ack_n = 1'b1;
    addr = 7'h00;
    drv = 1'b0;
    drv_val = 8'h00;
    last_val = 8'h00;
  end

  // A released bus does not keep its last level
  assign data_in = data_oe ? data_out : (drv ? drv_val : ~last_val);

  always @(posedge clk) begin
    if (data_oe || drv) begin
      last_val <= data_in;
    end
  end

  task automatic idle_gap();
    repeat (6) @(negedge clk);
  endtask : idle_gap

  task automatic write_reg(input logic [6:0] a, input logic [7:0] d, input logic sel = 1'b1);
    @(negedge clk);
    chip_select_n = ~sel;
    write_strobe_n = 1'b0;
    addr = a;
    drv = 1'b1;
    drv_val = d;
    idle_gap();
    write_strobe_n = 1'b1;
    idle_gap();
    chip_select_n = 1'b1;
    drv = 1'b0;
    idle_gap();
  endtask : write_reg

  // Read cycle, or acknowledge cycle when ack is set
  task automatic fetch(input logic [6:0] a, input logic sel, input logic ack,
                       output logic [7:0] d, output logic seen);
    seen = 1'b0;
    d = 8'h00;
    @(negedge clk);
    if (ack) begin
      irq_ack_n = 1'b0;
    end else begin
      chip_select_n = ~sel;
      read_strobe_n = 1'b0;
      addr = a;
    end
    for (int i = 0; i < 10 && !seen; i++) begin
      @(negedge clk);
      seen = (data_oe === 1'b1);
    end
    repeat (2) @(negedge clk);
    d = data_out;
    read_strobe_n = 1'b1;
    chip_select_n = 1'b1;
    irq_ack_n = 1'b1;
    idle_gap();
  endtask : fetch
endmodule : shbp_host_model

// ==== shbp_port_bench.sv ====
// Self-checking bench of the strobe host bus port
`timescale 1ns/1ns
`include "shbp_map.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module shbp_port_bench;
  logic clk, rst, bus_style_select, rxd, rx_level, tx_bit, tx_busy, txd;
  logic chip_select_n, write_strobe_n, read_strobe_n, irq_ack_n, data_oe, irq_out_n, irq_oe;
  logic timer_run, rx_enable, tx_enable, loopback;
  logic [6:0] addr;
  logic [7:0] data_in, data_out, chan_status, io_out, io_oe, mode1, mode2, baud_sel;
  logic [10:0] int_cond;
  logic [7:0] d;
  logic seen;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [6:0] clr_addr [7] = '{`SHBP_ADDR_STATUS, `SHBP_ADDR_IMR_LO, `SHBP_ADDR_IMR_HI,
    `SHBP_ADDR_ISR_LO, `SHBP_ADDR_ISR_HI, `SHBP_ADDR_OPR, `SHBP_ADDR_OUT_PORT_CFG_REG};
  logic [6:0] t_addr [5] = '{`SHBP_ADDR_OPR, `SHBP_ADDR_OUT_PORT_CFG_REG, `SHBP_ADDR_BAUD, 7'h20, 7'h7F};
  logic [7:0] t_data [5] = '{8'h96, 8'h69, 8'h5C, 8'h3C, 8'hC3};

  shbp_port shbp_port_inst (.clk(clk), .rst(rst), .bus_style_select(bus_style_select),
    .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .irq_ack_n(irq_ack_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .irq_out_n(irq_out_n), .irq_oe(irq_oe),
    .int_cond(int_cond), .chan_status(chan_status), .rxd(rxd), .rx_level(rx_level),
    .tx_bit(tx_bit), .tx_busy(tx_busy), .txd(txd), .io_out(io_out), .io_oe(io_oe),
    .timer_run(timer_run), .rx_enable(rx_enable), .tx_enable(tx_enable),
    .loopback(loopback), .mode1(mode1), .mode2(mode2), .baud_sel(baud_sel));

  shbp_host_model shbp_host_model_inst (.clk(clk), .data_out(data_out), .data_oe(data_oe),
    .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .irq_ack_n(irq_ack_n), .addr(addr), .data_in(data_in));

  // ----------------------------------------------------------------
  // Access helpers and run control
  // ----------------------------------------------------------------
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    shbp_host_model_inst.write_reg(a, v);
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input logic ack = 1'b0);
    logic [7:0] v;
    logic s;
    shbp_host_model_inst.fetch(a, 1'b1, ack, v, s);
    `CHK(s, 1'b1)
    `CHK(v, exp)
  endtask : rd_chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    bus_style_select = 1'b1;
    int_cond = 11'h000;
    chan_status = 8'hA5;
    rxd = 1'b1;
    tx_bit = 1'b0;
    tx_busy = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    `CHK({mode1, mode2, baud_sel}, {`SHBP_MODE1_RST, `SHBP_MODE2_RST, `SHBP_BAUD_9600})
    `CHK({io_oe, io_out}, 16'h0000)
    `CHK({timer_run, rx_enable, tx_enable, loopback}, 4'h0)
    `CHK(txd, 1'b1)
    `CHK({irq_oe, data_oe}, 2'h0)
    foreach (clr_addr[i]) rd_chk(clr_addr[i], 8'h00);
    foreach (t_addr[i]) wr(t_addr[i], t_data[i]);
    foreach (t_addr[i]) rd_chk(t_addr[i], t_data[i]);
    `CHK({io_out, io_oe, baud_sel}, 24'h96695C)
    wr(`SHBP_ADDR_MODE, 8'h21);
    wr(`SHBP_ADDR_MODE, 8'h42);
    wr(`SHBP_ADDR_MODE, 8'h55);
    `CHK({mode1, mode2}, 16'h2155)
    wr(`SHBP_ADDR_CTRL, 8'h10);
    wr(`SHBP_ADDR_MODE, 8'h66);
    `CHK(mode1, 8'h66)
    shbp_host_model_inst.write_reg(`SHBP_ADDR_OPR, 8'hFF, 1'b0);
    `CHK(io_out, 8'h96)
    shbp_host_model_inst.fetch(`SHBP_ADDR_OPR, 1'b0, 1'b0, d, seen);
    `CHK(seen, 1'b0)
    bus_style_select = 1'b0;
    wr(`SHBP_ADDR_OPR, 8'hFF);
    `CHK(io_out, 8'h96)
    bus_style_select = 1'b1;
    int_cond = 11'h008;
    repeat (4) @(negedge clk);
    `CHK(irq_oe, 1'b0)
    rd_chk(`SHBP_ADDR_ISR_LO, 8'h08);
    wr(`SHBP_ADDR_IMR_LO, 8'h08);
    `CHK({irq_oe, irq_out_n}, 2'b10)
    wr(`SHBP_ADDR_ISR_LO, 8'h08);
    `CHK(irq_oe, 1'b1)
    int_cond = 11'h400;
    wr(`SHBP_ADDR_ISR_LO, 8'h08);
    `CHK(irq_oe, 1'b0)
    wr(`SHBP_ADDR_IMR_HI, 8'h04);
    `CHK(irq_oe, 1'b1)
    rd_chk(`SHBP_ADDR_ISR_HI, 8'h04);
    int_cond = 11'h000;
    wr(`SHBP_ADDR_ISR_HI, 8'h04);
    `CHK(irq_oe, 1'b0)
    rd_chk(7'h00, `SHBP_VECTOR_RST, 1'b1);
    wr(`SHBP_ADDR_VECTOR, 8'h5A);
    rd_chk(7'h00, 8'h5A, 1'b1);
    wr(`SHBP_ADDR_CTRL, 8'h02);
    `CHK(rx_enable, 1'b1)
    rd_chk(`SHBP_ADDR_STATUS, 8'hA5);
    wr(`SHBP_ADDR_CTRL, 8'h05);
    `CHK({timer_run, rx_enable, tx_enable, loopback, txd}, 5'b10100)
    tx_busy = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(txd, 1'b1)
    tx_busy = 1'b1;
    wr(`SHBP_ADDR_CTRL, 8'h0C);
    `CHK(txd, 1'b1)
    rxd = 1'b0;
    repeat (6) @(negedge clk);
    `CHK(rx_level, 1'b0)
    rxd = 1'b1;
    repeat (6) @(negedge clk);
    `CHK(rx_level, 1'b1)
    wr(`SHBP_ADDR_IMR_LO, 8'h01);
    int_cond = 11'h001;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    int_cond = 11'h000;
    rst = 1'b0;
    repeat (5) @(negedge clk);
    `CHK({irq_oe, txd, io_out, io_oe, mode1}, {2'b01, 16'h0000, `SHBP_MODE1_RST})
    `CHK({timer_run, tx_enable, loopback}, 3'h0)
    rd_chk(`SHBP_ADDR_IMR_LO, 8'h00);
    end_sim();
  end
endmodule : shbp_port_bench
